// ==== hw/prefetch_limits_pkg.sv ====
// Constants, types and helpers for the upstream read pre-fetch limits block
// Behaviour
// - A burst read count of zero switches the automatic pre-fetch agent off.
// - A burst read count of one keeps a thread to one buffer, no pre-fetch.
// - Counts two to fifteen allow the first read plus count minus one more.
// - Cache policy 00 disables pre-fetch and drops leftovers once data went.
// - Light caching drops leftovers on master end, keeps them on a retry.
// - Full caching keeps leftovers on master end and on a bridge retry.
// - Thread length is 64 bytes shifted by the code, 0 to 7; 8 to 15 reserved.
// - Bits 15:12 and 5:4 of the limits register always read as zero.
// - Link, global and power-on reset all restore the limit fields.
// - The limits register resets to 0443h: count 4, policy 01, 512 bytes.
`default_nettype none
package prefetch_limits_pkg;

   // Register placement and layout
   localparam logic [7:0] LIMITS_OFFSET = 8'hE8;
   localparam int CNT_LSB = 8;
   localparam int MODE_LSB = 6;
   localparam int LEN_LSB = 0;
   localparam logic [15:0] LIMITS_RESET = 16'h0443;
   localparam logic [15:0] LIMITS_WMASK = 16'h0FCF;

   // Field codes
   localparam logic [1:0] CACHE_NONE = 2'h0;
   localparam logic [1:0] CACHE_LIGHT = 2'h1;
   localparam logic [1:0] CACHE_FULL = 2'h2;
   localparam logic [3:0] CNT_SINGLE = 4'h1;
   localparam logic [3:0] LEN_MAX_CODE = 4'h7;
   localparam logic [13:0] LEN_BASE_BYTES = 14'h0040;

   // Read sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ISSUE = 2'b01
   } seq_state_t;

   // Byte length of a thread; reserved codes fall back to the smallest
   function automatic logic [13:0] thread_bytes(input logic [3:0] code);
      if (code > LEN_MAX_CODE)
         return LEN_BASE_BYTES;
      return LEN_BASE_BYTES << code[2:0];
   endfunction

   // Reads per burst, the initial read included
   function automatic logic [3:0] burst_reads(input logic [3:0] cnt,
                                              input logic [1:0] mode);
      if (cnt <= CNT_SINGLE || !(mode == CACHE_LIGHT || mode == CACHE_FULL))
         return CNT_SINGLE;
      return cnt;
   endfunction

endpackage
`default_nettype wire

// ==== hw/completion_disposition.sv ====
// Decides whether leftover read completion data is cached or discarded
`timescale 1ns/1ps
`default_nettype none
module completion_disposition (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Policy and thread events
   input wire logic [1:0] policy,
   input wire logic thread_start,
   input wire logic data_returned,
   input wire logic xfer_end,
   input wire logic end_by_retry,
   // Verdict
   output logic discard_q,
   output logic cached_q
);

   logic sent_q;
   logic sent_d;
   logic keep;
   logic drop;
   logic discard_d;
   logic cached_d;

   // Verdict at transfer end; nothing is dropped before data has gone out
   assign keep = (policy == prefetch_limits_pkg::CACHE_FULL) ||
                 (policy == prefetch_limits_pkg::CACHE_LIGHT &&
                  end_by_retry);
   assign drop = xfer_end && (sent_q || data_returned) && !keep;
   // Data handed out in the start cycle still counts for the new thread
   assign sent_d = data_returned || (sent_q && !thread_start);
   assign discard_d = drop;
   // A hold verdict in the same cycle wins over a new thread's clear
   assign cached_d = drop ? 1'b0 :
                     (xfer_end && keep) ? 1'b1 :
                     thread_start ? 1'b0 : cached_q;

   // Verdict flops
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sent_q <= 1'b0;
         discard_q <= 1'b0;
         cached_q <= 1'b0;
      end else begin
         sent_q <= sent_d;
         discard_q <= discard_d;
         cached_q <= cached_d;
      end
   end

   chk_none_drops: assert property (@(posedge mclk) disable iff (!rstn)
      xfer_end && data_returned && !thread_start &&
      policy == prefetch_limits_pkg::CACHE_NONE |=> discard_q && !cached_q)
      else $error("policy 00 kept leftover data");
   chk_light_split: assert property (@(posedge mclk) disable iff (!rstn)
      xfer_end && data_returned && !thread_start &&
      policy == prefetch_limits_pkg::CACHE_LIGHT
      |=> discard_q != $past(end_by_retry) &&
      cached_q == $past(end_by_retry))
      else $error("light caching chose wrong verdict");
   chk_full_keeps: assert property (@(posedge mclk) disable iff (!rstn)
      xfer_end && !thread_start &&
      policy == prefetch_limits_pkg::CACHE_FULL |=> !discard_q && cached_q)
      else $error("full caching discarded data");
   chk_rsvd_policy: assert property (@(posedge mclk) disable iff (!rstn)
      xfer_end && data_returned && policy == 2'h3 |=> discard_q)
      else $error("reserved policy kept data");

endmodule // completion_disposition
`default_nettype wire

// ==== hw/upstream_read_prefetch_limits.sv ====
// Pre-fetch agent limits register and upstream read burst sequencer
`timescale 1ns/1ps
`default_nettype none
module upstream_read_prefetch_limits #(
   parameter int ADDR_W = 32
) (
   // Clock and combined link, global and power-on reset
   input wire logic mclk,
   input wire logic rstn,
   // Configuration access
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [1:0] cfg_be,
   input wire logic [15:0] cfg_wdata,
   output logic [15:0] cfg_rdata_q,
   output logic cfg_ack_q,
   // Secondary-bus master read thread
   input wire logic thread_start,
   input wire logic [ADDR_W-1:0] thread_addr,
   input wire logic data_returned,
   input wire logic xfer_end,
   input wire logic end_by_retry,
   // Upstream read requests
   output logic req_valid_q,
   output logic [ADDR_W-1:0] req_addr_q,
   output logic [13:0] req_len_q,
   input wire logic req_ready,
   // Agent status and leftover data verdict
   output logic prefetch_on_q,
   output logic busy_q,
   output logic discard_q,
   output logic cached_q
);

   // Register and its fields
   logic [15:0] limits_q;
   logic [15:0] limits_d;
   logic [15:0] wr_bits;
   logic [3:0] burst_read_count;
   logic [1:0] completion_cache_policy;
   logic [3:0] thread_byte_length;
   logic hit;
   logic wr_hit;

   // Sequencer state
   prefetch_limits_pkg::seq_state_t state_q;
   prefetch_limits_pkg::seq_state_t state_d;
   logic [3:0] reads_left_q;
   logic [3:0] reads_left_d;
   logic [ADDR_W-1:0] req_addr_d;
   logic [13:0] req_len_d;
   logic req_valid_d;
   logic accept;
   logic handshake;
   logic last_read;
   logic [3:0] first_total;
   logic [15:0] rdata_d;
   logic pf_on_d;

   // Field views of the register
   assign burst_read_count = limits_q[prefetch_limits_pkg::CNT_LSB +: 4];
   assign completion_cache_policy =
      limits_q[prefetch_limits_pkg::MODE_LSB +: 2];
   assign thread_byte_length = limits_q[prefetch_limits_pkg::LEN_LSB +: 4];

   // Address decode and byte-lane write merge
   assign hit = (cfg_addr == prefetch_limits_pkg::LIMITS_OFFSET);
   assign wr_hit = cfg_wr && hit;
   assign wr_bits = {{8{cfg_be[1]}}, {8{cfg_be[0]}}} &
                    prefetch_limits_pkg::LIMITS_WMASK;
   assign limits_d = wr_hit ? ((limits_q & ~wr_bits) | (cfg_wdata & wr_bits))
                            : limits_q;
   // Unused ranges never store, so they always read back zero
   assign rdata_d = (cfg_rd && hit) ?
                    (limits_q & prefetch_limits_pkg::LIMITS_WMASK) :
                    16'h0000;

   // Limits register; every reset source arrives merged on rstn
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         limits_q <= prefetch_limits_pkg::LIMITS_RESET;
      end else begin
         limits_q <= limits_d;
      end
   end

   // Access answer one cycle after the strobe
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cfg_rdata_q <= 16'h0000;
         cfg_ack_q <= 1'b0;
      end else begin
         cfg_rdata_q <= rdata_d;
         cfg_ack_q <= cfg_rd || cfg_wr;
      end
   end

   // Burst sizing; count and policy are sampled once per thread
   assign first_total = prefetch_limits_pkg::burst_reads(burst_read_count,
                           completion_cache_policy);
   assign pf_on_d = (burst_read_count > prefetch_limits_pkg::CNT_SINGLE) &&
                    (completion_cache_policy ==
                        prefetch_limits_pkg::CACHE_LIGHT ||
                     completion_cache_policy ==
                        prefetch_limits_pkg::CACHE_FULL);
   assign accept = (state_q == prefetch_limits_pkg::ST_IDLE) && thread_start;
   assign handshake = req_valid_q && req_ready;
   assign last_read = (reads_left_q == prefetch_limits_pkg::CNT_SINGLE);

   // Next-state logic of the sequencer
   always_comb begin
      state_d = state_q;
      reads_left_d = reads_left_q;
      req_valid_d = req_valid_q;
      req_addr_d = req_addr_q;
      req_len_d = req_len_q;
      case (state_q)
         prefetch_limits_pkg::ST_IDLE: begin
            if (thread_start) begin
               state_d = prefetch_limits_pkg::ST_ISSUE;
               reads_left_d = first_total;
               req_valid_d = 1'b1;
               req_addr_d = thread_addr;
               req_len_d = prefetch_limits_pkg::thread_bytes(
                              thread_byte_length);
            end
         end
         prefetch_limits_pkg::ST_ISSUE: begin
            if (handshake) begin
               if (last_read) begin
                  state_d = prefetch_limits_pkg::ST_IDLE;
                  req_valid_d = 1'b0;
               end else begin
                  // Next pre-fetch follows on from the previous thread span
                  reads_left_d = reads_left_q - 4'h1;
                  req_addr_d = req_addr_q + ADDR_W'(req_len_q);
               end
            end
         end
         default: begin
            state_d = prefetch_limits_pkg::ST_IDLE;
            req_valid_d = 1'b0;
         end
      endcase
   end

   // Sequencer flops; a start while busy is ignored, not queued
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= prefetch_limits_pkg::ST_IDLE;
         reads_left_q <= 4'h0;
         req_valid_q <= 1'b0;
         req_addr_q <= '0;
         req_len_q <= 14'h0000;
      end else begin
         state_q <= state_d;
         reads_left_q <= reads_left_d;
         req_valid_q <= req_valid_d;
         req_addr_q <= req_addr_d;
         req_len_q <= req_len_d;
      end
   end

   // Status flops
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prefetch_on_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         prefetch_on_q <= pf_on_d;
         busy_q <= (state_d == prefetch_limits_pkg::ST_ISSUE);
      end
   end

   // Leftover completion data handling
   completion_disposition u_disposition (
      .mclk(mclk),
      .rstn(rstn),
      .policy(completion_cache_policy),
      .thread_start(accept),
      .data_returned(data_returned),
      .xfer_end(xfer_end),
      .end_by_retry(end_by_retry),
      .discard_q(discard_q),
      .cached_q(cached_q)
   );

   // Helper state for the checks below
   logic [3:0] issued_q;
   logic [3:0] limit_seen_q;
   logic [3:0] len_code_q;
   logic touched_q;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         issued_q <= 4'h0;
         limit_seen_q <= 4'h0;
         len_code_q <= 4'h0;
         touched_q <= 1'b0;
      end else begin
         if (accept) begin
            issued_q <= 4'h0;
            limit_seen_q <= first_total;
            len_code_q <= thread_byte_length;
         end else if (handshake) begin
            issued_q <= issued_q + 4'h1;
         end
         touched_q <= touched_q || wr_hit;
      end
   end

   chk_single_read: assert property (@(posedge mclk) disable iff (!rstn)
      accept && (burst_read_count <= prefetch_limits_pkg::CNT_SINGLE) ##1
      handshake |=> !req_valid_q && state_q == prefetch_limits_pkg::ST_IDLE)
      else $error("pre-fetch issued with count of zero or one");
   chk_one_buffer: assert property (@(posedge mclk) disable iff (!rstn)
      accept && burst_read_count == prefetch_limits_pkg::CNT_SINGLE
      |=> reads_left_q == 4'h1)
      else $error("count one did not limit thread to one buffer");
   chk_burst_bound: assert property (@(posedge mclk) disable iff (!rstn)
      handshake |-> issued_q < limit_seen_q)
      else $error("burst exceeded programmed read count");
   chk_no_pf_none: assert property (@(posedge mclk) disable iff (!rstn)
      accept && completion_cache_policy == prefetch_limits_pkg::CACHE_NONE
      |=> reads_left_q == 4'h1 && !prefetch_on_q)
      else $error("pre-fetch ran under policy 00");
   chk_len_value: assert property (@(posedge mclk) disable iff (!rstn)
      req_valid_q |->
      req_len_q == prefetch_limits_pkg::thread_bytes(len_code_q))
      else $error("thread length does not match code");
   chk_addr_step: assert property (@(posedge mclk) disable iff (!rstn)
      handshake && !last_read |=>
      req_addr_q == $past(req_addr_q) + ADDR_W'($past(req_len_q)))
      else $error("pre-fetch address did not advance by thread length");
   chk_rsvd_zero: assert property (@(posedge mclk) disable iff (!rstn)
      cfg_ack_q |-> cfg_rdata_q[15:12] == 4'h0 && cfg_rdata_q[5:4] == 2'h0)
      else $error("unused bits read nonzero");
   chk_reset_default: assert property (@(posedge mclk)
      disable iff (!rstn)
      !touched_q && !wr_hit |=> limits_q == prefetch_limits_pkg::LIMITS_RESET)
      else $error("limits register lost its default");

   // Every strobe is answered on the very next edge
   chk_ack_follow: assert property (@(posedge mclk) disable iff (!rstn)
      cfg_rd || cfg_wr |=> cfg_ack_q)
      else $error("config access went unanswered");

   // An answer never appears without a strobe before it
   chk_ack_extra: assert property (@(posedge mclk) disable iff (!rstn)
      !cfg_rd && !cfg_wr |=> !cfg_ack_q)
      else $error("config answer without a strobe");

   // Read data stays quiet outside a read of this register
   chk_rd_idle: assert property (@(posedge mclk) disable iff (!rstn)
      !(cfg_rd && hit) |=> cfg_rdata_q == 16'h0000)
      else $error("read data driven without a read hit");

   // The unused ranges never hold a one, whatever was written
   chk_rsvd_store: assert property (@(posedge mclk) disable iff (!rstn)
      limits_q[15:12] == 4'h0 && limits_q[5:4] == 2'h0)
      else $error("unused register bits stored a one");

   // A full-width write lands as written, less the unused ranges
   chk_wr_lands: assert property (@(posedge mclk) disable iff (!rstn)
      wr_hit && cfg_be == 2'h3 |=>
      limits_q == ($past(cfg_wdata) & prefetch_limits_pkg::LIMITS_WMASK))
      else $error("register write did not land");

   // A count of zero leaves the agent switched off
   chk_count_off: assert property (@(posedge mclk) disable iff (!rstn)
      burst_read_count == 4'h0 |=> !prefetch_on_q)
      else $error("agent enabled with a count of zero");

   // The reserved policy behaves as no caching, so no pre-fetch
   chk_rsvd_nopf: assert property (@(posedge mclk) disable iff (!rstn)
      completion_cache_policy == 2'h3 |=> !prefetch_on_q)
      else $error("agent enabled under the reserved policy");

   // First request carries the thread address on the next cycle
   chk_first_req: assert property (@(posedge mclk) disable iff (!rstn)
      accept |=> req_valid_q && busy_q && req_addr_q == $past(thread_addr))
      else $error("first read of a thread went astray");

   // A stalled request holds still until it is taken
   chk_valid_hold: assert property (@(posedge mclk) disable iff (!rstn)
      req_valid_q && !req_ready |=>
      req_valid_q && $stable(req_addr_q) && $stable(req_len_q))
      else $error("request changed while stalled");

   // The last read of a burst is exactly the programmed one
   chk_burst_full: assert property (@(posedge mclk) disable iff (!rstn)
      handshake && last_read |-> issued_q + 4'h1 == limit_seen_q)
      else $error("burst ended short of its read count");

   // Busy and request valid rise and fall together
   chk_busy_valid: assert property (@(posedge mclk) disable iff (!rstn)
      busy_q == req_valid_q)
      else $error("busy flag out of step with requests");

   // Nothing is requested while the sequencer idles
   chk_idle_quiet: assert property (@(posedge mclk) disable iff (!rstn)
      state_q == prefetch_limits_pkg::ST_IDLE |-> !req_valid_q)
      else $error("request raised while idle");

   // Reserved length codes fall back to the smallest span
   chk_rsvd_len: assert property (@(posedge mclk) disable iff (!rstn)
      accept && thread_byte_length > prefetch_limits_pkg::LEN_MAX_CODE
      |=> req_len_q == prefetch_limits_pkg::LEN_BASE_BYTES)
      else $error("reserved length code gave a long read");

   // The largest code reads a full 8 Kbyte span
   chk_len_top: assert property (@(posedge mclk) disable iff (!rstn)
      accept && thread_byte_length == prefetch_limits_pkg::LEN_MAX_CODE
      |=> req_len_q == 14'h2000)
      else $error("largest length code read the wrong span");

endmodule // upstream_read_prefetch_limits
`default_nettype wire

// ==== sim/upstream_read_sink.sv ====
// Upstream read request sink that can stall between requests
`timescale 1ns/1ps
`default_nettype none
module upstream_read_sink (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Request handshake
   input wire logic slow,
   input wire logic req_valid_q,
   output logic ready_q
);
   // A slow sink refuses one cycle after each take, so bursts must hold
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn)
         ready_q <= 1'b0;
      else
         ready_q <= !(slow && req_valid_q && ready_q);
   end
endmodule // upstream_read_sink
`default_nettype wire

// ==== sim/test_upstream_read_prefetch_limits.sv ====
// Self-checking bench for the pre-fetch limits register and burst sequencer
`timescale 1ns/1ps
`default_nettype none
module test_upstream_read_prefetch_limits;
   logic mclk, rstn, cfg_wr, cfg_rd, cfg_ack_q, slow, req_ready;
   logic thread_start, data_returned, xfer_end, end_by_retry;
   logic req_valid_q, prefetch_on_q, busy_q, discard_q, cached_q;
   logic [7:0] cfg_addr;
   logic [1:0] cfg_be;
   logic [15:0] cfg_wdata, cfg_rdata_q, rd;
   logic [31:0] thread_addr, req_addr_q;
   logic [13:0] req_len_q;
   int n_errors, tests_run;

   upstream_read_prefetch_limits #(.ADDR_W(32))
      upstream_read_prefetch_limits_i (
      .mclk(mclk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
      .cfg_rdata_q(cfg_rdata_q), .cfg_ack_q(cfg_ack_q),
      .thread_start(thread_start), .thread_addr(thread_addr),
      .data_returned(data_returned), .xfer_end(xfer_end),
      .end_by_retry(end_by_retry), .req_valid_q(req_valid_q),
      .req_addr_q(req_addr_q), .req_len_q(req_len_q), .req_ready(req_ready),
      .prefetch_on_q(prefetch_on_q), .busy_q(busy_q),
      .discard_q(discard_q), .cached_q(cached_q));

   upstream_read_sink upstream_read_sink_i (.mclk(mclk), .rstn(rstn),
      .slow(slow), .req_valid_q(req_valid_q), .ready_q(req_ready));

   // Free-running 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic finish_test;
      if (n_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic cmp_val(input logic [31:0] got, exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t ns: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // One config access; read data lands in rd with the ack
   task automatic cfg(input logic wr, input logic [7:0] a,
                      input logic [1:0] be, input logic [15:0] d);
      @(posedge mclk);
      cfg_wr <= wr;
      cfg_rd <= !wr;
      cfg_addr <= a;
      cfg_be <= be;
      cfg_wdata <= d;
      @(posedge mclk);
      cfg_wr <= 1'b0;
      cfg_rd <= 1'b0;
      #1;
      rd = cfg_rdata_q;
      cmp_val(cfg_ack_q, 1'b1, "ack");
   endtask

   // Program limits, start one thread and follow every request it makes
   task automatic burst(input logic [3:0] cnt, input logic [1:0] pol,
                        input logic [3:0] code, input logic s);
      logic [31:0] len, base;
      int n, k, c;
      n = (cnt <= 1 || pol == 2'h0 || pol == 2'h3) ? 1 : int'(cnt);
      len = (code > 4'h7) ? 32'h40 : 32'h40 << code;
      base = 32'h0001_0000;
      k = 0;
      cfg(1'b1, 8'hE8, 2'h3, {4'h0, cnt, pol, 2'h0, code});
      @(posedge mclk);
      slow <= s;
      thread_start <= 1'b1;
      thread_addr <= base;
      @(posedge mclk);
      thread_start <= 1'b0;
      // Look just after each edge, once the outputs have settled
      for (c = 0; c < 200; c++) begin
         #1;
         if (req_valid_q && req_ready) begin
            cmp_val(busy_q, 1'b1, "busy");
            cmp_val(req_addr_q, base + len * k, "address");
            cmp_val(req_len_q, len, "length");
            k++;
         end
         if (k > 0 && !busy_q && !req_valid_q)
            break;
         @(posedge mclk);
      end
      if (c == 200) begin
         n_errors++;
         $display("Error at %0t ns: burst never finished", $time);
         finish_test;
      end
      cmp_val(k, n, "reads per burst");
      cmp_val(prefetch_on_q, n > 1, "agent enable");
   endtask

   // End a transfer after a short burst and judge the leftover verdict
   task automatic dispose(input logic [1:0] pol, input logic data,
                          input logic retry, input logic disc, cached);
      burst(4'h2, pol, 4'h0, 1'b0);
      @(posedge mclk);
      data_returned <= data;
      xfer_end <= 1'b1;
      end_by_retry <= retry;
      @(posedge mclk);
      data_returned <= 1'b0;
      xfer_end <= 1'b0;
      end_by_retry <= 1'b0;
      #1;
      cmp_val(discard_q, disc, "discard");
      cmp_val(cached_q, cached, "cached");
   endtask

   // Main sequence
   initial begin
      n_errors = 0;
      tests_run = 0;
      rstn = 1'b0;
      {cfg_wr, cfg_rd, thread_start, data_returned, slow} = 5'h00;
      {xfer_end, end_by_retry, cfg_be} = 4'h0;
      cfg_addr = 8'h00;
      cfg_wdata = 16'h0000;
      thread_addr = 32'h0000_0000;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      cfg(1'b0, 8'hE8, 2'h3, 16'h0000);
      cmp_val(rd, 16'h0443, "reset value");
      cfg(1'b1, 8'hE8, 2'h1, 16'hFFFF);
      cfg(1'b0, 8'hE8, 2'h3, 16'h0000);
      cmp_val(rd, 16'h04CF, "low lane write");
      cfg(1'b1, 8'hE8, 2'h3, 16'hFFFF);
      cfg(1'b0, 8'hE8, 2'h3, 16'h0000);
      cmp_val(rd, 16'h0FCF, "all ones write");
      cfg(1'b1, 8'hEA, 2'h3, 16'h1234);
      cfg(1'b0, 8'hEA, 2'h3, 16'h0000);
      cmp_val(rd, 16'h0000, "unmapped read");
      burst(4'h0, 2'h1, 4'h3, 1'b0);
      burst(4'h1, 2'h2, 4'h0, 1'b1);
      burst(4'hF, 2'h2, 4'h2, 1'b1);
      burst(4'h4, 2'h0, 4'h3, 1'b0);
      burst(4'h4, 2'h3, 4'h1, 1'b0);
      for (int c = 0; c < 16; c++)
         burst(4'h3, 2'h1, c[3:0], c[0]);
      dispose(2'h0, 1'b1, 1'b0, 1'b1, 1'b0);
      dispose(2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      dispose(2'h1, 1'b1, 1'b0, 1'b1, 1'b0);
      dispose(2'h1, 1'b1, 1'b1, 1'b0, 1'b1);
      dispose(2'h2, 1'b1, 1'b0, 1'b0, 1'b1);
      dispose(2'h2, 1'b1, 1'b1, 1'b0, 1'b1);
      dispose(2'h3, 1'b1, 1'b1, 1'b1, 1'b0);
      // Second reset in mid-run must bring the defaults back
      cfg(1'b1, 8'hE8, 2'h3, 16'h0000);
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      cfg(1'b0, 8'hE8, 2'h3, 16'h0000);
      cmp_val(rd, 16'h0443, "value after reset");
      finish_test;
   end
endmodule // test_upstream_read_prefetch_limits
`default_nettype wire
